// ---- hw/chmc_top.sv ----
// charge mode control logic: fast / trickle decision with latched causes
// assumes comparator outputs arrive as asynchronous levels, AHB-Lite master
//
// Summary of operation
// - start in fast mode after reset
// - trickle drives active-low output low
// - any programming input high selects time
// - all inputs low: temperature mode, timer off
// - programming code selects fast charge limit
// - under temperature in temperature mode forces unlatched trickle
// - warming past lower limit resumes fast
// - over temperature in temperature mode sets latch, trickle
// - over-temperature latch holds until reset pulse
// - pack reconnect or supply cycle clears latch
// - window entry gives fast and reset pulse
// - sense outside window forces trickle
// - two slope events after holdoff latch trickle
// - latched trickle leaves only on reset pulse
// - timer reaching limit latches trickle
// - temperature mode inside limits allows fast
// - fast only with sense and backup good
// - undervoltage holds trickle, resets timer, latch
// - sense below window resets slope detection
`timescale 1ns/10ps
module chmc_top #(
    parameter int unsigned holdoff_cycles = 32'(64'(chmc_pkg::holdoff_s) * 64'(chmc_pkg::clk_hz)),
    parameter int unsigned minute_cycles  = chmc_pkg::minute_s * chmc_pkg::clk_hz
) (
    input  wire logic        hclk,                // system clock, 25 MHz
    input  wire logic        hresetn,             // async reset, active low
    input  wire logic        hsel,                // slave select
    input  wire logic [31:0] haddr,               // byte address
    input  wire logic [1:0]  htrans,              // transfer type
    input  wire logic        hwrite,              // write when high
    input  wire logic [2:0]  hsize,               // transfer size
    input  wire logic [31:0] hwdata,              // write data
    input  wire logic        hready,              // bus ready in
    output logic      [31:0] hrdata,              // read data
    output logic             hreadyout,           // slave ready
    output logic             hresp,               // always okay
    input  wire logic        sense_low_in,        // sense below 1.0 v
    input  wire logic        sense_high_in,       // sense above 2.0 v
    input  wire logic        slope_event_in,      // one negative slope event
    input  wire logic        under_temp_in,       // colder than lower limit
    input  wire logic        over_temp_in,        // hotter than upper limit
    input  wire logic        supply_uvlo_in,      // supply undervoltage
    input  wire logic        lower_limit_prog_in, // above select threshold
    input  wire logic        thermistor_prog_in,  // above select threshold
    input  wire logic        upper_limit_prog_in, // above select threshold
    output logic             fast_trickle_n       // low means trickle
);
    localparam int n_in = 9;

    logic [n_in-1:0] raw_in;
    logic [n_in-1:0] syn;

    assign raw_in = {upper_limit_prog_in, thermistor_prog_in, lower_limit_prog_in,
                     supply_uvlo_in, over_temp_in, under_temp_in,
                     slope_event_in, sense_high_in, sense_low_in};

    chmc_sync #(
        .width    (n_in)
    ) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .async_in (raw_in),
        .sync_out (syn)
    );

    logic s_low;
    logic s_high;
    logic s_slope;
    logic s_cold;
    logic s_hot;
    logic s_uvlo;
    logic [2:0] s_prog;

    assign s_low   = syn[0];
    assign s_high  = syn[1];
    assign s_slope = syn[2];
    assign s_cold  = syn[3];
    assign s_hot   = syn[4];
    assign s_uvlo  = syn[5];
    assign s_prog  = syn[8:6];

    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        chmc_pkg::chmc_mode_t mode;
        logic        ot_latch;
        logic        full_latch;
        logic        timeout_latch;
        logic        in_window;
        logic        slope_prev;
        logic [1:0]  slope_cnt;
        logic [31:0] holdoff_cnt;
        logic [31:0] tick_cnt;
        logic [8:0]  minutes;
        logic        enable;
        logic        soft_reset;
        logic        out_n;
        logic        ap_valid;
        logic        ap_write;
        logic [7:0]  ap_addr;
        logic [31:0] rdata;
    } chmc_state_t;

    chmc_state_t cur;
    chmc_state_t next_s;

    logic       window;
    logic       time_mode;
    logic [8:0] limit;
    logic       reset_pulse;
    logic       slope_rise;
    logic       hold_done;
    logic       minute_tick;
    logic       any_latch;
    logic       fast_ok;

    // any input open selects time mode
    assign time_mode = |s_prog;

    always_comb
    begin
        unique case ({s_prog[0], s_prog[1], s_prog[2]})
            3'h7: limit = chmc_pkg::limit_min_7;
            3'h6: limit = chmc_pkg::limit_min_6;
            3'h5: limit = chmc_pkg::limit_min_5;
            3'h4: limit = chmc_pkg::limit_min_4;
            3'h3: limit = chmc_pkg::limit_min_3;
            3'h2: limit = chmc_pkg::limit_min_2;
            3'h1: limit = chmc_pkg::limit_min_1;
            default: limit = 9'h000;
        endcase
    end

    assign window      = !s_low && !s_high;
    // latched exit only on this pulse
    // uvlo also resets timer and latch
    assign reset_pulse = (window && !cur.in_window) || s_uvlo || cur.soft_reset;
    assign slope_rise  = s_slope && !cur.slope_prev;
    assign hold_done   = cur.holdoff_cnt >= 32'(holdoff_cycles);
    assign minute_tick = cur.tick_cnt == 32'(minute_cycles - 1);
    assign any_latch   = cur.ot_latch || cur.full_latch || cur.timeout_latch;
    // fast needs sense and backup good
    assign fast_ok     = window && !s_uvlo && cur.enable && (time_mode || !s_cold);

    always_comb
    begin
        next_s = cur;
        next_s.in_window  = window;
        next_s.slope_prev = s_slope;
        next_s.soft_reset = 1'b0;

        // ************************************************
        // latches
        // ************************************************
        // all latches clear together
        if (reset_pulse)
        begin
            next_s.ot_latch      = 1'b0;
            next_s.full_latch    = 1'b0;
            next_s.timeout_latch = 1'b0;
        end
        if (s_hot && !time_mode && !s_uvlo)
            next_s.ot_latch = 1'b1;

        // ************************************************
        // charge timer
        // ************************************************
        if (reset_pulse || !time_mode || cur.mode != chmc_pkg::chmc_fast)
        begin
            next_s.tick_cnt = 32'h0000_0000;
            if (reset_pulse)
                next_s.minutes = 9'h000;
        end
        else if (minute_tick)
        begin
            next_s.tick_cnt = 32'h0000_0000;
            next_s.minutes  = cur.minutes + 9'h001;
        end
        else
            next_s.tick_cnt = cur.tick_cnt + 32'h0000_0001;
        if (time_mode && cur.minutes >= limit && !s_uvlo)
            next_s.timeout_latch = 1'b1;

        // ************************************************
        // negative slope detection
        // ************************************************
        // sense low resets slope logic
        if (s_low || reset_pulse)
        begin
            next_s.slope_cnt   = 2'h0;
            next_s.holdoff_cnt = 32'h0000_0000;
        end
        else if (cur.mode == chmc_pkg::chmc_fast)
        begin
            if (!hold_done)
                next_s.holdoff_cnt = cur.holdoff_cnt + 32'h0000_0001;
            if (slope_rise && hold_done)
            begin
                next_s.slope_cnt = cur.slope_cnt + 2'h1;
                if (cur.slope_cnt == 2'h1)
                    next_s.full_latch = 1'b1;
            end
        end

        // ************************************************
        // mode
        // ************************************************
        // latched causes override fast
        if (next_s.ot_latch || next_s.full_latch || next_s.timeout_latch)
            next_s.mode = chmc_pkg::chmc_latched;
        else if (!fast_ok)
            next_s.mode = chmc_pkg::chmc_trickle;
        else
            next_s.mode = chmc_pkg::chmc_fast;

        next_s.out_n = next_s.mode == chmc_pkg::chmc_fast;

        // ************************************************
        // ahb-lite slave, zero wait states
        // ************************************************
        if (cur.ap_valid && cur.ap_write)
        begin
            if (cur.ap_addr == chmc_pkg::ctrl_addr)
            begin
                next_s.soft_reset = hwdata[chmc_pkg::ctrl_soft_reset_bit];
                next_s.enable     = hwdata[chmc_pkg::ctrl_enable_bit];
            end
        end
        next_s.ap_valid = hsel && hready && htrans[1];
        next_s.ap_write = hwrite;
        next_s.ap_addr  = haddr[7:0];
        next_s.rdata    = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite)
        begin
            unique case (haddr[7:0])
                chmc_pkg::ctrl_addr:
                    next_s.rdata[chmc_pkg::ctrl_enable_bit] = cur.enable;
                chmc_pkg::status_addr:
                begin
                    next_s.rdata[chmc_pkg::st_fast_bit]      = cur.mode == chmc_pkg::chmc_fast;
                    next_s.rdata[chmc_pkg::st_time_mode_bit] = time_mode;
                    next_s.rdata[chmc_pkg::st_ot_latch_bit]  = cur.ot_latch;
                    next_s.rdata[chmc_pkg::st_full_bit]      = cur.full_latch;
                    next_s.rdata[chmc_pkg::st_timeout_bit]   = cur.timeout_latch;
                    next_s.rdata[chmc_pkg::st_cold_bit]      = s_cold;
                    next_s.rdata[chmc_pkg::st_window_bit]    = window;
                    next_s.rdata[chmc_pkg::st_uvlo_bit]      = s_uvlo;
                    next_s.rdata[chmc_pkg::st_slope_cnt_lsb +: 2] = cur.slope_cnt;
                end
                chmc_pkg::timer_addr:
                    next_s.rdata[8:0] = cur.minutes;
                chmc_pkg::limit_addr:
                    next_s.rdata[8:0] = limit;
                default:
                    next_s.rdata = 32'h0000_0000;
            endcase
        end
    end

    // reset state is fast, output high
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cur            <= '0;
            cur.mode       <= chmc_pkg::chmc_fast;
            cur.enable     <= chmc_pkg::ctrl_reset_value[chmc_pkg::ctrl_enable_bit];
            cur.soft_reset <= 1'b0;
            cur.out_n      <= 1'b1;
            cur.in_window  <= 1'b1;
        end
        else
            cur <= next_s;
    end

    assign fast_trickle_n = cur.out_n;
    assign hrdata         = cur.rdata;
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
endmodule

// ---- include/chmc_pkg.sv ----
// package for the charge mode control logic: register map, fields, timing
// assumes a 25 MHz hclk and an AHB-Lite master with single word transfers
package chmc_pkg;

    // ************************************************
    // register offsets (byte addresses)
    // ************************************************
    localparam logic [7:0] ctrl_addr    = 8'h00;
    localparam logic [7:0] status_addr  = 8'h04;
    localparam logic [7:0] timer_addr   = 8'h08;
    localparam logic [7:0] limit_addr   = 8'h0c;

    // ************************************************
    // ctrl fields
    // ************************************************
    localparam int ctrl_soft_reset_bit = 0;
    localparam int ctrl_enable_bit     = 1;
    localparam logic [1:0] ctrl_reset_value = 2'h2;

    // ************************************************
    // status fields
    // ************************************************
    localparam int st_fast_bit      = 0;
    localparam int st_time_mode_bit = 1;
    localparam int st_ot_latch_bit  = 2;
    localparam int st_full_bit      = 3;
    localparam int st_timeout_bit   = 4;
    localparam int st_cold_bit      = 5;
    localparam int st_window_bit    = 6;
    localparam int st_uvlo_bit      = 7;
    localparam int st_slope_cnt_lsb = 8;

    // ************************************************
    // timing
    // ************************************************
    localparam int  clk_hz          = 25_000_000;
    localparam int  holdoff_s       = 160;
    localparam int  minute_s        = 60;
    // one-second prescaler count, least time rounded up
    localparam int  sec_cycles      = clk_hz;
    localparam logic [24:0] sec_last = 25'(sec_cycles - 1);

    // time limits in minutes, indexed by {lower, thermistor, upper}
    localparam logic [8:0] limit_min_7 = 9'h11b;  // 283
    localparam logic [8:0] limit_min_6 = 9'h0f7;  // 247
    localparam logic [8:0] limit_min_5 = 9'h0d4;  // 212
    localparam logic [8:0] limit_min_4 = 9'h0b1;  // 177
    localparam logic [8:0] limit_min_3 = 9'h08d;  // 141
    localparam logic [8:0] limit_min_2 = 9'h06a;  // 106
    localparam logic [8:0] limit_min_1 = 9'h047;  // 71

    typedef enum logic [2:0]
    {
        chmc_fast    = 3'h1,
        chmc_trickle = 3'h2,
        chmc_latched = 3'h4
    } chmc_mode_t;

endpackage

// ---- hw/chmc_sync.sv ----
// two-flop synchroniser bank for the comparator results
// assumes inputs are asynchronous levels from the analog front end
`timescale 1ns/10ps
module chmc_sync #(
    parameter int width = 8
) (
    input  wire logic             hclk,     // system clock
    input  wire logic             hresetn,  // async reset, active low
    input  wire logic [width-1:0] async_in, // raw comparator levels
    output logic      [width-1:0] sync_out  // synchronised levels
);
    logic [width-1:0] stage1;

    // ************************************************
    // per-bit double flop
    // ************************************************
    genvar i;
    generate
        for (i = 0; i < width; i++)
        begin : g_bit
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    stage1[i]   <= 1'b0;
                    sync_out[i] <= 1'b0;
                end
                else
                begin
                    stage1[i]   <= async_in[i];
                    sync_out[i] <= stage1[i];
                end
            end
        end
    endgenerate
endmodule

// ---- sim/chmc_regulator.sv ----
// far-side charge current regulator model
// assumes it only follows the fast/trickle level of the block
`timescale 1ns/10ps
module chmc_regulator (
    input  wire logic hclk,           // system clock
    input  wire logic fast_trickle_n, // low asks for trickle
    output logic      fast_current    // high while fast current flows
);
    // ****************************************
    // current source
    // ****************************************
    // low selects trickle
    always_ff @(posedge hclk)
        fast_current <= fast_trickle_n;
endmodule

// ---- sim/chmc_top_asserts.sv ----
// checker for the charge mode control logic, bound to chmc_top
// assumes three edges from comparator input to fast_trickle_n
`timescale 1ns/10ps
module chmc_asserts #(
    parameter int unsigned holdoff_cycles = 50,
    parameter int unsigned minute_cycles  = 20
) (
    input wire logic        hclk,                // system clock
    input wire logic        hresetn,             // async reset
    input wire logic        hsel,                // slave select
    input wire logic [1:0]  htrans,              // transfer type
    input wire logic        hwrite,              // write
    input wire logic        hready,              // bus ready
    input wire logic [31:0] hrdata,              // read data
    input wire logic        hreadyout,           // slave ready
    input wire logic        hresp,               // response
    input wire logic        sense_low_in,        // sense low
    input wire logic        sense_high_in,       // sense high
    input wire logic        under_temp_in,       // too cold
    input wire logic        over_temp_in,        // too hot
    input wire logic        supply_uvlo_in,      // supply low
    input wire logic        lower_limit_prog_in, // prog input
    input wire logic        thermistor_prog_in,  // prog input
    input wire logic        upper_limit_prog_in, // prog input
    input wire logic        fast_trickle_n       // low means trickle
);
    wire temp_mode = !(lower_limit_prog_in || thermistor_prog_in || upper_limit_prog_in);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ****************************************
    // mode checks
    // ****************************************
    a_reset_fast: assert property ($rose(hresetn) |-> fast_trickle_n)
        else $error("not fast after reset");
    a_window_trickle: assert property ((sense_low_in || sense_high_in)[*5] |-> !fast_trickle_n)
        else $error("fast outside sense window");
    a_uvlo_trickle: assert property (supply_uvlo_in[*5] |-> !fast_trickle_n)
        else $error("fast during lockout");
    a_cold_trickle: assert property (under_temp_in[*5] |-> !fast_trickle_n)
        else $error("fast while cold");
    a_hot_trickle: assert property ((over_temp_in && temp_mode && !supply_uvlo_in)[*5] |-> !fast_trickle_n)
        else $error("fast while hot");
    a_hot_holds: assert property ((!fast_trickle_n && temp_mode && $fell(over_temp_in) && !sense_low_in
        && !sense_high_in && !supply_uvlo_in) |-> (!fast_trickle_n)[*8])
        else $error("over temperature trickle released");
    a_fast_cause: assert property ($rose(fast_trickle_n) |-> $past(!sense_low_in && !sense_high_in
        && !supply_uvlo_in && !under_temp_in, 3))
        else $error("fast without good inputs");
    a_bus_okay: assert property (hreadyout && !hresp) // bus contract
        else $error("bus not ready or error");
    a_rdata_idle: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 32'h0) // bus contract
        else $error("read data outside data phase");
    cover property ($fell(fast_trickle_n));
    cover property ($rose(fast_trickle_n));
    cover property (over_temp_in && temp_mode);
endmodule
bind chmc_top chmc_asserts #(.holdoff_cycles(holdoff_cycles), .minute_cycles(minute_cycles)) chmc_asserts_i (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .sense_low_in,
    .sense_high_in, .under_temp_in, .over_temp_in, .supply_uvlo_in, .lower_limit_prog_in,
    .thermistor_prog_in, .upper_limit_prog_in, .fast_trickle_n);

// ---- sim/test_charge_mode_control_logic.sv ----
// testbench for the charge mode control logic
// assumes holdoff of 50 and minute of 20 cycles via parameters
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_charge_mode_control_logic;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, fast_trickle_n, fast_current;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        sense_low_in, sense_high_in, slope_event_in, under_temp_in, over_temp_in, supply_uvlo_in;
    logic        lower_limit_prog_in, thermistor_prog_in, upper_limit_prog_in;
    logic [8:0]  limits [8] = '{9'h000, 9'h047, 9'h06a, 9'h08d, 9'h0b1, 9'h0d4, 9'h0f7, 9'h11b};
    int          failures, samples_checked;

    chmc_top #(.holdoff_cycles(50), .minute_cycles(20)) chmc_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sense_low_in, .sense_high_in,
        .slope_event_in, .under_temp_in, .over_temp_in, .supply_uvlo_in, .lower_limit_prog_in,
        .thermistor_prog_in, .upper_limit_prog_in, .fast_trickle_n);
    chmc_regulator chmc_regulator_i (.hclk, .fast_trickle_n, .fast_current);

    // ****************************************
    // helpers
    // ****************************************
    task automatic settle(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        // take read data while it stands, not in the edge that clears it
        do
        begin
            #1;
            rdv = hrdata;
            @(posedge hclk);
        end while (hreadyout !== 1'b1);
    endtask
    // leaves the window, then comes back: a reset pulse
    task automatic window_pulse(input logic high);
        @(posedge hclk);
        sense_high_in <= high;
        sense_low_in  <= !high;
        settle(5);
        `CHK(fast_trickle_n, 1'b0)
        `CHK(fast_current, 1'b0)
        @(posedge hclk);
        sense_high_in <= 1'b0;
        sense_low_in  <= 1'b0;
        settle(5);
    endtask
    task automatic slope_ev;
        @(posedge hclk) slope_event_in <= 1'b1;
        settle(4);
        @(posedge hclk) slope_event_in <= 1'b0;
        settle(4);
    endtask
    task end_sim;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        settle(5);
        `CHK(fast_trickle_n, 1'b1)
        `CHK(fast_current, 1'b1)
        bus(0, chmc_pkg::ctrl_addr, 32'h0);
        `CHK(rdv, 32'h2)
        bus(0, chmc_pkg::status_addr, 32'h0);
        `CHK(rdv[1:0], 2'h1)
        bus(1, 8'h40, 32'hffff_ffff);
        bus(0, 8'h40, 32'h0);
        `CHK(rdv, 32'h0)
        bus(1, chmc_pkg::ctrl_addr, 32'h0);
        settle(2);
        `CHK(fast_trickle_n, 1'b0)
        bus(1, chmc_pkg::ctrl_addr, 32'h2);
        settle(2);
        `CHK(fast_trickle_n, 1'b1)
    endtask
    task automatic t_sense;
        window_pulse(1'b1);
        `CHK(fast_trickle_n, 1'b1)
        window_pulse(1'b0);
        `CHK(fast_trickle_n, 1'b1)
    endtask
    task automatic t_cold;
        @(posedge hclk) under_temp_in <= 1'b1;
        settle(5);
        `CHK(fast_trickle_n, 1'b0)
        @(posedge hclk) under_temp_in <= 1'b0;
        settle(5);
        `CHK(fast_trickle_n, 1'b1)
    endtask
    task automatic t_hot;
        @(posedge hclk) over_temp_in <= 1'b1;
        settle(5);
        `CHK(fast_trickle_n, 1'b0)
        bus(0, chmc_pkg::status_addr, 32'h0);
        `CHK(rdv[2], 1'b1)
        @(posedge hclk) over_temp_in <= 1'b0;
        settle(10);
        `CHK(fast_trickle_n, 1'b0)
        window_pulse(1'b0);
        `CHK(fast_trickle_n, 1'b1)
        bus(0, chmc_pkg::status_addr, 32'h0);
        `CHK(rdv[2], 1'b0)
    endtask
    task automatic t_slope;
        settle(60);
        slope_ev;
        `CHK(fast_trickle_n, 1'b1)
        window_pulse(1'b0);
        settle(60);
        slope_ev;
        `CHK(fast_trickle_n, 1'b1)
        slope_ev;
        `CHK(fast_trickle_n, 1'b0)
        bus(0, chmc_pkg::status_addr, 32'h0);
        `CHK(rdv[3], 1'b1)
        settle(20);
        `CHK(fast_trickle_n, 1'b0)
        bus(1, chmc_pkg::ctrl_addr, 32'h3);
        settle(5);
        `CHK(fast_trickle_n, 1'b1)
    endtask
    task automatic t_uvlo;
        @(posedge hclk) over_temp_in <= 1'b1;
        settle(5);
        @(posedge hclk) over_temp_in <= 1'b0;
        @(posedge hclk) supply_uvlo_in <= 1'b1;
        settle(8);
        `CHK(fast_trickle_n, 1'b0)
        bus(0, chmc_pkg::status_addr, 32'h0);
        `CHK(rdv[7], 1'b1)
        @(posedge hclk) supply_uvlo_in <= 1'b0;
        settle(5);
        `CHK(fast_trickle_n, 1'b1)
    endtask
    task automatic t_time;
        for (int c = 7; c >= 1; c--)
        begin
            @(posedge hclk);
            lower_limit_prog_in <= c[2];
            thermistor_prog_in  <= c[1];
            upper_limit_prog_in <= c[0];
            settle(5);
            bus(0, chmc_pkg::limit_addr, 32'h0);
            `CHK(rdv[8:0], limits[c])
            bus(0, chmc_pkg::status_addr, 32'h0);
            `CHK(rdv[1], 1'b1)
        end
        bus(1, chmc_pkg::ctrl_addr, 32'h3);
        settle(1360);
        `CHK(fast_trickle_n, 1'b1)
        settle(100);
        `CHK(fast_trickle_n, 1'b0)
        @(posedge hclk) upper_limit_prog_in <= 1'b0;
        bus(1, chmc_pkg::ctrl_addr, 32'h3);
        settle(50);
        `CHK(fast_trickle_n, 1'b1)
        bus(0, chmc_pkg::timer_addr, 32'h0);
        `CHK(rdv, 32'h0)
    endtask

    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // whole run is near 2000 cycles; allow five times that
    initial
    begin
        #400000;
        failures++;
        end_sim;
    end
    initial
    begin
        failures = 0;
        samples_checked = 0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        sense_low_in = 1'b0;
        sense_high_in = 1'b0;
        slope_event_in = 1'b0;
        under_temp_in = 1'b0;
        over_temp_in = 1'b0;
        supply_uvlo_in = 1'b0;
        // board tie: temperature mode, window held
        lower_limit_prog_in = 1'b0;
        thermistor_prog_in = 1'b0;
        upper_limit_prog_in = 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_sense;
        t_cold;
        t_hot;
        t_slope;
        t_uvlo;
        t_time;
        end_sim;
    end
endmodule
